/* File: tb/bridge_signal_correction_bench.sv */
// Self-checking bench for the correction block
`timescale 1ns/1ps
`define CHK(a, b) begin n_checks++; if ((a) !== (b)) begin fail_count++; \
  $display("[FAIL] %0t got %h exp %h", $time, a, b); end end
module bridge_signal_correction_bench;
  import bridge_corr_pkg::*;
  logic sys_clk_in, rstn_in, corr_start_in, cmd_valid_in, meas_start_out, meas_is_temp_out;
  logic result_valid_out, sf;
  logic [7:0]  cmd_code_in, status_out;
  logic [15:0] cmd_data_in, meas_setup_out, result_out, id_low_out, id_high_out, bridge_setup_out;
  corr_in_s corr_in;
  int fail_count = 0, n_checks = 0, cyc = 0;
  corr_in_s vec [8] = '{'{0, 1000, 0, 0, 0, 0, 0, 0, 32768, 0, 0},
    '{131071, 0, -131072, 0, 0, 0, 0, 0, 32768, 0, 0}, '{0, -100000, 0, 0, 0, 0, 0, 0, 32768, 0, 0},
    '{0, 100000, 0, 0, 0, 0, 0, 0, 32768, 0, 0}, '{0, 1000, 0, 0, 0, 0, 0, 0, 32768, 0, 0},
    '{2000, 20000, 1000, 5000, -700, 300, 100, 50, 30000, -2000, 0},
    '{2000, 20000, 1000, 5000, -700, 300, 100, 50, 30000, -2000, 1},
    '{131071, -100000, 0, 0, 131071, 0, 0, 0, 32768, 0, 0}};
  host_model host (.clk_in(sys_clk_in), .valid_out(cmd_valid_in), .code_out(cmd_code_in),
    .data_out(cmd_data_in));
  bridge_signal_correction dut (.sys_clk_in, .rstn_in, .cmd_valid_in, .cmd_code_in, .cmd_data_in,
    .cmd_ready_out(), .meas_start_out, .meas_is_temp_out, .meas_setup_out, .corr_start_in,
    .corr_in, .result_valid_out, .result_out, .status_out, .id_low_out, .id_high_out,
    .bridge_setup_out);
  initial begin
    sys_clk_in = 1'b0;
    forever #50 sys_clk_in = ~sys_clk_in;
  end
  // Clamp with flag; every clamp must reach the status bit
  function automatic longint s(longint v, longint lo = -131072, longint hi = 131071);
    if (v > hi || v < lo) sf = 1'b1;
    return (v > hi) ? hi : (v < lo) ? lo : v;
  endfunction
  function automatic longint m(longint a, longint b);
    return s((a * b) >>> 15);
  endfunction
  task automatic expect_of(input corr_in_s c, output logic [15:0] b, output logic f);
    longint dt, k1, k2, z;
    sf = 1'b0;
    dt = s(longint'(c.temp_raw) - c.ref_temp);
    k1 = s(32768 + m(dt, s(m(c.gain_drift2, dt) + c.gain_drift)));
    k2 = s(c.bridge_offset + s(c.bridge_raw + m(dt, s(m(c.offset_drift2, dt) + c.offset_drift))));
    z = m(c.bridge_gain, m(k1, k2));
    if (!c.shape_select) begin
      z = s(z + 32768, 0);
      z = s(m(z, s(m(c.bridge2, z) + 32768)), 0, 65535);
    end else begin
      z = s(m(z, s(m(c.bridge2, (z < 0) ? -z : z) + 32768)) + 32768, 0, 65535);
    end
    b = z[15:0];
    f = sf;
  endtask
  task automatic run(input corr_in_s c);
    logic [15:0] eb;
    logic ef;
    int k;
    expect_of(c, eb, ef);
    @(negedge sys_clk_in);
    corr_in = c;
    corr_start_in = 1'b1;
    @(negedge sys_clk_in);
    corr_start_in = 1'b0;
    k = 0;
    while (result_valid_out !== 1'b1 && k < 20) begin
      @(negedge sys_clk_in);
      k++;
    end
    `CHK(result_valid_out, 1'b1)
    `CHK(result_out, eb)
    `CHK(status_out[STATUS_SAT_BIT], ef)
  endtask
  task automatic cmd(input logic [7:0] c, input logic [15:0] d, input logic st,
    input logic [15:0] su);
    host.send(c, d);
    `CHK(meas_start_out, st)
    if (st) `CHK(meas_setup_out, su)
  endtask
  task automatic end_of_test;
    $display("checks %0d mismatches %0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  // Hang guard, far above the roughly 130 cycles needed
  always @(posedge sys_clk_in) begin
    cyc++;
    if (cyc == 2000) begin
      fail_count++;
      end_of_test();
    end
  end
  initial begin
    rstn_in = 1'b0;
    corr_start_in = 1'b0;
    corr_in = '0;
    repeat (6) @(negedge sys_clk_in);
    rstn_in = 1'b1;
    `CHK(id_low_out, ID_RESET)
    cmd(CMD_WR_ID_LOW, 16'h1234, 1'b0, 16'h0000);
    `CHK(id_low_out, 16'h1234)
    cmd(CMD_WR_ID_HIGH, 16'hbeef, 1'b0, 16'h0000);
    `CHK(id_high_out, 16'hbeef)
    cmd(8'h50, 16'h0a5c, 1'b0, 16'h0000);
    cmd(CMD_RAW_BRIDGE_STORED, 16'h0000, 1'b1, 16'h0a5c);
    cmd(CMD_RAW_BRIDGE_STORED, 16'h0001, 1'b0, 16'h0000);
    cmd(CMD_RAW_BRIDGE_GIVEN, 16'h3c41, 1'b1, 16'h3c41);
    cmd(CMD_RAW_TEMP_PRESET, 16'h0000, 1'b1, TEMP_SETUP_PRESET);
    cmd(CMD_RAW_TEMP_PRESET, 16'h0001, 1'b0, 16'h0000);
    cmd(CMD_RAW_TEMP_GIVEN, 16'h7e02, 1'b1, 16'h7e02);
    for (int i = 0; i < 8; i++) run(vec[i]);
    end_of_test();
  end
endmodule
bind bridge_signal_correction bridge_signal_correction_checker chk (.sys_clk_in, .rstn_in,
  .cmd_valid_in, .cmd_code_in, .cmd_data_in, .meas_start_out, .meas_is_temp_out, .meas_setup_out,
  .corr_start_in, .result_valid_out, .id_low_out, .id_high_out, .bridge_setup_out);

/* File: tb/bridge_signal_correction_checker.sv */
// Port assertions for the correction block
`timescale 1ns/1ps
module bridge_signal_correction_checker
  import bridge_corr_pkg::*;
(
  input wire logic        sys_clk_in,
  input wire logic        rstn_in,
  input wire logic        cmd_valid_in,
  input wire logic [7:0]  cmd_code_in,
  input wire logic [15:0] cmd_data_in,
  input wire logic        meas_start_out,
  input wire logic        meas_is_temp_out,
  input wire logic [15:0] meas_setup_out,
  input wire logic        corr_start_in,
  input wire logic        result_valid_out,
  input wire logic [15:0] id_low_out,
  input wire logic [15:0] id_high_out,
  input wire logic [15:0] bridge_setup_out
);
  default clocking dc @(posedge sys_clk_in); endclocking
  default disable iff (!rstn_in);
  a_id_low_write: assert property (cmd_valid_in && cmd_code_in == CMD_WR_ID_LOW |=>
    id_low_out == $past(cmd_data_in)) else $error("id low");
  a_id_high_write: assert property (cmd_valid_in && cmd_code_in == CMD_WR_ID_HIGH |=>
    id_high_out == $past(cmd_data_in)) else $error("id high");
  a_bridge_stored: assert property (cmd_valid_in && cmd_code_in == 8'ha2 && cmd_data_in == 0
    |=> meas_start_out && !meas_is_temp_out && meas_setup_out == $past(bridge_setup_out))
    else $error("stored setup");
  a_bridge_refused: assert property (cmd_valid_in && cmd_code_in == 8'ha2 && cmd_data_in != 0
    |=> !meas_start_out) else $error("nonzero a2");
  a_temp_refused: assert property (cmd_valid_in && cmd_code_in == 8'ha6 && cmd_data_in != 0
    |=> !meas_start_out) else $error("nonzero a6");
  a_start_cause: assert property (meas_start_out |-> $past(cmd_valid_in))
    else $error("stray start");
  a_bridge_given: assert property (cmd_valid_in && cmd_code_in == 8'ha3 |=>
    meas_start_out && !meas_is_temp_out && meas_setup_out == $past(cmd_data_in))
    else $error("given setup");
  a_temp_preset: assert property (cmd_valid_in && cmd_code_in == 8'ha6 && cmd_data_in == 0
    |=> meas_start_out && meas_is_temp_out && meas_setup_out == TEMP_SETUP_PRESET)
    else $error("preset temp");
  a_temp_given: assert property (cmd_valid_in && cmd_code_in == 8'ha7 |=>
    meas_start_out && meas_is_temp_out && meas_setup_out == $past(cmd_data_in))
    else $error("given temp");
  a_result_latency: assert property (result_valid_out |-> $past(corr_start_in, 12))
    else $error("late result");
endmodule

/* File: tb/host_model.sv */
// Calibration host model driving the command port
`timescale 1ns/1ps
module host_model (
  // Clock
  input  wire logic clk_in,
  // Command port
  output logic      valid_out,
  output logic [7:0]  code_out,
  output logic [15:0] data_out
);
  initial begin
    valid_out = 1'b0;
    code_out  = 8'h00;
    data_out  = 16'h0000;
  end
  // Command with its word, one cycle
  task automatic send(input logic [7:0] c, input logic [15:0] d);
    @(negedge clk_in);
    valid_out = 1'b1;
    code_out  = c;
    data_out  = d;
    @(negedge clk_in);
    valid_out = 1'b0;
    data_out  = ~d; // Idle word never repeats the last one
  endtask
endmodule

/* File: verilog/bridge_corr_pkg.sv */
// Shared constants and types for the bridge correction datapath
package bridge_corr_pkg;
  localparam int DW = 18;
  localparam logic signed [17:0] SAT_MAX = 18'sh1ffff;
  localparam logic signed [17:0] SAT_MIN = -18'sh20000;
  localparam logic signed [17:0] ONE_Q15 = 18'sh08000;
  localparam int SHIFT = 15;
  localparam logic [7:0] CMD_WR_ID_LOW = 8'h40;
  localparam logic [7:0] CMD_WR_ID_HIGH = 8'h41;
  localparam logic [7:0] CMD_RAW_BRIDGE_STORED = 8'ha2;
  localparam logic [7:0] CMD_RAW_BRIDGE_GIVEN = 8'ha3;
  localparam logic [7:0] CMD_RAW_TEMP_PRESET = 8'ha6;
  localparam logic [7:0] CMD_RAW_TEMP_GIVEN = 8'ha7;
  localparam logic [5:0] ADDR_ID_LOW = 6'h00;
  localparam logic [5:0] ADDR_ID_HIGH = 6'h01;
  localparam logic [5:0] ADDR_BRIDGE_SETUP = 6'h10;
  localparam logic [15:0] ID_RESET = 16'h0000;
  localparam logic [15:0] SETUP_RESET = 16'h0000;
  localparam logic [15:0] TEMP_SETUP_PRESET = 16'h0000;
  localparam logic [15:0] OUT_MAX = 16'hffff;
  localparam int STATUS_SAT_BIT = 0;
  localparam int PIPE_STEPS = 9;
  typedef struct packed {
    logic signed [17:0] temp_raw;
    logic signed [17:0] bridge_raw;
    logic signed [17:0] ref_temp;
    logic signed [17:0] gain_drift;
    logic signed [17:0] offset_drift;
    logic signed [17:0] gain_drift2;
    logic signed [17:0] offset_drift2;
    logic signed [17:0] bridge_offset;
    logic signed [17:0] bridge_gain;
    logic signed [17:0] bridge2;
    logic               shape_select;
  } corr_in_s;
  typedef struct packed {
    logic [5:0]  addr;
    logic [15:0] data;
  } mem_wr_s;
endpackage

/* File: verilog/bridge_signal_correction.sv */
// Bridge correction datapath with calibration command handling
// Contract
// - Identity words written by 40/41 land at addresses zero and one.
// - A2 with zero data measures bridge using stored setup word.
// - A3 measures bridge using the setup word sent with it.
// - A6 with zero data measures temperature using preset setup.
// - A7 measures temperature using the setup word sent with it.
// - Any intermediate saturation is flagged in status bit zero.
// - Shape select zero means parabolic, otherwise S-shaped.
// - Temperature difference is raw minus reference, saturated to 18 bits.
// - Gain factor from drift terms, each step saturated.
// - Offset term sums offset, raw bridge and drift correction, saturated.
// - Output: intermediate times second-order term plus one, clamped.
// - Corrected output is unsigned 16 bits, zero to ffff.
`timescale 1ns/1ps
module bridge_signal_correction
  import bridge_corr_pkg::*;
(
  // Clock and reset
  input  wire logic                     sys_clk_in,
  input  wire logic                     rstn_in,
  // Command port
  input  wire logic                     cmd_valid_in,
  input  wire logic [7:0]               cmd_code_in,
  input  wire logic [15:0]              cmd_data_in,
  output logic                          cmd_ready_out,
  // Measurement request to front end
  output logic                          meas_start_out,
  output logic                          meas_is_temp_out,
  output logic [15:0]                   meas_setup_out,
  // Correction request
  input  wire logic                     corr_start_in,
  input  wire bridge_corr_pkg::corr_in_s corr_in,
  // Results
  output logic                          result_valid_out,
  output logic [15:0]                   result_out,
  output logic [7:0]                    status_out,
  output logic [15:0]                   id_low_out,
  output logic [15:0]                   id_high_out,
  output logic [15:0]                   bridge_setup_out
);
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_RUN  = 2'b01,
    ST_DONE = 2'b10
  } state_e;

  state_e             state;
  state_e             next_state;
  logic [3:0]         step;
  logic [3:0]         next_step;
  logic signed [17:0] dt, k1, k2, z, tmp;
  logic signed [17:0] next_dt, next_k1, next_k2, next_z, next_tmp;
  logic               sat;
  logic               next_sat;
  logic [15:0]        result;
  logic [15:0]        next_result;
  logic               rvalid;
  logic               next_rvalid;
  logic [15:0]        id_low, id_high, setup;
  logic [15:0]        next_id_low, next_id_high, next_setup;
  logic               mstart, mtemp;
  logic               next_mstart, next_mtemp;
  logic [15:0]        msetup;
  logic [15:0]        next_msetup;
  corr_in_s           op;
  corr_in_s           next_op;

  logic signed [17:0] ua, ub, uadd, uy;
  logic               umul, usat;
  logic signed [18:0] dt_diff;

  // Wide subtract; negating the reference in 18 bits would wrap
  assign dt_diff = 19'(op.temp_raw) - 19'(op.ref_temp);

  sat_mul_unit u_alu (
    .a_in    (ua),
    .b_in    (ub),
    .add_in  (uadd),
    .mul_in  (umul),
    .y_out   (uy),
    .sat_out (usat)
  );

  function automatic logic signed [17:0] clamp_pos(input logic signed [17:0] v);
    clamp_pos = (v < 18'sh0) ? 18'sh0 : v;
  endfunction

  // Command decode
  always_comb begin
    next_id_low = id_low;
    next_id_high = id_high;
    next_setup = setup;
    next_mstart = 1'b0;
    next_mtemp = mtemp;
    next_msetup = msetup;
    if (cmd_valid_in) begin
      case (cmd_code_in)
        CMD_WR_ID_LOW: next_id_low = cmd_data_in;
        CMD_WR_ID_HIGH: next_id_high = cmd_data_in;
        CMD_RAW_BRIDGE_STORED: begin
          if (cmd_data_in == 16'h0000) begin
            next_mstart = 1'b1;
            next_mtemp = 1'b0;
            next_msetup = setup;
          end
        end
        CMD_RAW_BRIDGE_GIVEN: begin
          next_mstart = 1'b1;
          next_mtemp = 1'b0;
          next_msetup = cmd_data_in;
        end
        CMD_RAW_TEMP_PRESET: begin
          if (cmd_data_in == 16'h0000) begin
            next_mstart = 1'b1;
            next_mtemp = 1'b1;
            next_msetup = TEMP_SETUP_PRESET;
          end
        end
        CMD_RAW_TEMP_GIVEN: begin
          next_mstart = 1'b1;
          next_mtemp = 1'b1;
          next_msetup = cmd_data_in;
        end
        default: begin
          // Memory write base plus setup address
          if (cmd_code_in == CMD_WR_ID_LOW + {2'b00, ADDR_BRIDGE_SETUP}) begin
            next_setup = cmd_data_in;
          end
        end
      endcase
    end
  end

  // Step sequencing: one ALU operation per cycle
  always_comb begin
    next_state = state;
    next_step = step;
    next_dt = dt;
    next_k1 = k1;
    next_k2 = k2;
    next_z = z;
    next_tmp = tmp;
    next_sat = sat;
    next_result = result;
    next_rvalid = 1'b0;
    next_op = op;
    ua = 18'sh0;
    ub = 18'sh0;
    uadd = 18'sh0;
    umul = 1'b0;
    case (state)
      ST_IDLE: begin
        if (corr_start_in) begin
          next_op = corr_in;
          next_sat = 1'b0;
          next_step = 4'h0;
          next_state = ST_RUN;
        end
      end
      ST_RUN: begin
        next_step = step + 4'h1;
        case (step)
          4'h0: begin
            if (dt_diff > 19'(SAT_MAX)) begin
              next_dt = SAT_MAX;
              next_sat = 1'b1;
            end else if (dt_diff < 19'(SAT_MIN)) begin
              next_dt = SAT_MIN;
              next_sat = 1'b1;
            end else begin
              next_dt = dt_diff[17:0];
            end
          end
          4'h1: begin
            ua = op.gain_drift2; ub = dt; umul = 1'b1; uadd = op.gain_drift;
            next_tmp = uy;
          end
          4'h2: begin ua = dt; ub = tmp; umul = 1'b1; uadd = ONE_Q15; next_k1 = uy; end
          4'h3: begin
            ua = op.offset_drift2; ub = dt; umul = 1'b1; uadd = op.offset_drift;
            next_tmp = uy;
          end
          4'h4: begin ua = dt; ub = tmp; umul = 1'b1; uadd = op.bridge_raw; next_tmp = uy; end
          4'h5: begin ua = op.bridge_offset; uadd = tmp; next_k2 = uy; end
          4'h6: begin ua = k1; ub = k2; umul = 1'b1; next_tmp = uy; end
          4'h7: begin
            ua = op.bridge_gain; ub = tmp; umul = 1'b1;
            uadd = op.shape_select ? 18'sh0 : ONE_Q15;
            next_z = op.shape_select ? uy : clamp_pos(uy);
            if (!op.shape_select && uy < 18'sh0) next_sat = 1'b1;
          end
          4'h8: begin
            ua = op.bridge2; ub = (op.shape_select && z < 18'sh0) ? -z : z;
            umul = 1'b1; uadd = ONE_Q15; next_tmp = uy;
          end
          default: begin
            ua = z; ub = tmp; umul = 1'b1;
            uadd = op.shape_select ? ONE_Q15 : 18'sh0;
            if (uy < 18'sh0) begin
              next_result = 16'h0000;
              next_sat = 1'b1;
            end else if (uy > 18'sh0ffff) begin
              next_result = OUT_MAX;
              next_sat = 1'b1;
            end else begin
              next_result = uy[15:0];
            end
            next_state = ST_DONE;
          end
        endcase
        if (usat) next_sat = 1'b1;
      end
      ST_DONE: begin
        next_rvalid = 1'b1;
        next_state = ST_IDLE;
      end
      default: next_state = ST_IDLE;
    endcase
  end

  always_ff @(posedge sys_clk_in) begin
    if (!rstn_in) begin
      state <= ST_IDLE;
      step <= 4'h0;
      dt <= 18'sh0;
      k1 <= 18'sh0;
      k2 <= 18'sh0;
      z <= 18'sh0;
      tmp <= 18'sh0;
      sat <= 1'b0;
      result <= 16'h0000;
      rvalid <= 1'b0;
      op <= '0;
      id_low <= ID_RESET;
      id_high <= ID_RESET;
      setup <= SETUP_RESET;
      mstart <= 1'b0;
      mtemp <= 1'b0;
      msetup <= 16'h0000;
    end else begin
      state <= next_state;
      step <= next_step;
      dt <= next_dt;
      k1 <= next_k1;
      k2 <= next_k2;
      z <= next_z;
      tmp <= next_tmp;
      sat <= next_sat;
      result <= next_result;
      rvalid <= next_rvalid;
      op <= next_op;
      id_low <= next_id_low;
      id_high <= next_id_high;
      setup <= next_setup;
      mstart <= next_mstart;
      mtemp <= next_mtemp;
      msetup <= next_msetup;
    end
  end

  // Commands never stall; measurement itself is external
  assign cmd_ready_out = 1'b1;
  assign meas_start_out = mstart;
  assign meas_is_temp_out = mtemp;
  assign meas_setup_out = msetup;
  assign result_valid_out = rvalid;
  assign result_out = result;
  assign status_out = {7'h00, sat};
  assign id_low_out = id_low;
  assign id_high_out = id_high;
  assign bridge_setup_out = setup;
endmodule

/* File: verilog/sat_mul_unit.sv */
// Scaled signed multiply and saturating add unit
`timescale 1ns/1ps
module sat_mul_unit
  import bridge_corr_pkg::*;
(
  // Operands
  input  wire logic signed [17:0] a_in,
  input  wire logic signed [17:0] b_in,
  input  wire logic signed [17:0] add_in,
  input  wire logic               mul_in,
  // Result
  output logic signed [17:0]      y_out,
  output logic                    sat_out
);
  logic signed [35:0] prod;
  logic signed [35:0] shifted;
  logic signed [17:0] term;
  logic               term_sat;
  logic signed [18:0] sum;
  always_comb begin
    prod = a_in * b_in;
    shifted = prod >>> SHIFT;
    term = a_in;
    term_sat = 1'b0;
    // Product clamps on its own first, so a large addend cannot mask it
    if (mul_in) begin
      if (shifted > 36'(SAT_MAX)) begin
        term = SAT_MAX;
        term_sat = 1'b1;
      end else if (shifted < 36'(SAT_MIN)) begin
        term = SAT_MIN;
        term_sat = 1'b1;
      end else begin
        term = shifted[17:0];
      end
    end
    sum = 19'(term) + 19'(add_in);
    sat_out = term_sat;
    if (sum > 19'(SAT_MAX)) begin
      y_out = SAT_MAX;
      sat_out = 1'b1;
    end else if (sum < 19'(SAT_MIN)) begin
      y_out = SAT_MIN;
      sat_out = 1'b1;
    end else begin
      y_out = sum[17:0];
    end
  end
endmodule
